// ==== t2s_pkg.sv ====
/*
 package of the split timer block: register offsets, field positions,
 mode codes, duty-capture states, timing constants and carrier structs.
 assumes a 32-bit ahb-lite register bus with byte addresses.
*/
package t2s_pkg;

	// register byte offsets, one 8-bit register per aligned word
	localparam logic [7:0] T2S_CTRL_OFS  = 8'h00;
	localparam logic [7:0] T2S_MODE_OFS  = 8'h04;
	localparam logic [7:0] T2S_MODE1_OFS = 8'h08;
	localparam logic [7:0] T2S_CNTL_OFS  = 8'h0c;
	localparam logic [7:0] T2S_CNTH_OFS  = 8'h10;
	localparam logic [7:0] T2S_CAPL_OFS  = 8'h14;
	localparam logic [7:0] T2S_CAPH_OFS  = 8'h18;

	// control register fields
	localparam int T2S_C_TF   = 7;
	localparam int T2S_C_EXF  = 6;
	localparam int T2S_C_B5   = 5;
	localparam int T2S_C_B4   = 4;
	localparam int T2S_C_EXEN = 3;
	localparam int T2S_C_RUN  = 2;
	localparam int T2S_C_CT   = 1;
	localparam int T2S_C_CPRL = 0;
	// mode register fields
	localparam int T2S_M_SPL  = 7;
	localparam int T2S_M_B6   = 6;
	localparam int T2S_M_RISE = 5;
	localparam int T2S_M_X12  = 4;
	localparam int T2S_M_LRUN = 3;
	localparam int T2S_M_LRC  = 2;
	localparam int T2S_M_OE   = 1;
	localparam int T2S_M_MS0  = 0;
	// mode register 1 fields
	localparam int T2S_M1_LCS  = 7;
	localparam int T2S_M1_IG   = 6;
	localparam int T2S_M1_BANK = 5;
	localparam int T2S_M1_CKS  = 4;
	localparam int T2S_M1_MS1  = 3;

	// mode codes {mode_select_high, capture_reload_select, mode_select_low}
	localparam logic [2:0] T2S_MD_AR   = 3'h0;
	localparam logic [2:0] T2S_MD_ARX  = 3'h1;
	localparam logic [2:0] T2S_MD_CAP  = 3'h2;
	localparam logic [2:0] T2S_MD_CAPZ = 3'h3;
	localparam logic [2:0] T2S_MD_PWM  = 3'h4;
	localparam logic [2:0] T2S_MD_DUTY = 3'h6;

	// timing and counts
	localparam logic [3:0]  T2S_DIV12_LAST = 4'hb;
	localparam logic [7:0]  T2S_BYTE_MAX   = 8'hff;
	localparam logic [15:0] T2S_WORD_MAX   = 16'hffff;
	localparam logic [31:0] T2S_RD_UNMAPPED = 32'h0000_0000;

	// duty capture sequence, gray coded along the path
	typedef enum logic [2:0] {
		T2S_D_IDLE   = 3'b000,
		T2S_D_WAIT   = 3'b001,
		T2S_D_FIRST  = 3'b011,
		T2S_D_SECOND = 3'b010,
		T2S_D_DONE   = 3'b110
	} t2s_duty_t;

	// external clock and event sources, synchronous one-cycle pulses except the raw count pin level
	typedef struct packed {
		logic count_pin;   // raw count pin level
		logic int0_evt;    // external interrupt 0 event
		logic serial_ovf;  // serial timer overflow
		logic t0_ovf;      // first-timer overflow
		logic t1_ovf;      // timer 1 overflow for baud
		logic acmp_evt;    // comparator event
		logic kbi_evt;     // keypad event
	} t2s_src_t;

	// complete state of the timer block
	typedef struct packed {
		logic        tf, exf, low_byte_overflow_flag;
		logic        rclk, tx_baud_source_sel, low_overflow_irq_enable, exen, run, ct, cprl;
		logic        spl, lbit, inv, rise_en, x12, lrun, lrc, oe, ms0;
		logic        lcs, ig, bank, cks, ms1;
		logic [2:0]  cap_src;
		logic [7:0]  cnt_h, cnt_l, cap_h, cap_l;
		t2s_duty_t   dstate;
		logic [3:0]  div;
		logic        trg_s1, trg_s2, trg_q, pin_s1, pin_s2, pin_q;
		logic        ckout, ovf_evt, tx_baud, rx_baud, irq;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] rdata;
		logic        ready;
	} t2s_state_t;

endpackage

// ==== t2s_timer.sv ====
/*
 second 16-bit timer with duty capture, split 8-bit modes, split pwm,
 baud generation and 50% clock output, with its registers on ahb-lite.
 assumes one clock hclk, source events synchronous one-cycle pulses,
 trigger and count pins raw levels, a single ahb master.
*/
`timescale 1ns/1ps
module t2s_timer
	import t2s_pkg::*;
(
	input  wire logic        hclk,                   // system clock
	input  wire logic        hresetn,                // asynchronous reset, low
	input  wire logic        hsel,                   // slave select
	input  wire logic [31:0] haddr,                  // byte address
	input  wire logic [1:0]  htrans,                 // transfer type
	input  wire logic        hwrite,                 // write request
	input  wire logic [2:0]  hsize,                  // word only
	input  wire logic [31:0] hwdata,                 // write data
	input  wire logic        hready,                 // bus ready in
	output logic      [31:0] hrdata,                 // read data
	output logic             hreadyout,              // slave ready
	output logic             hresp,                  // always okay
	input  wire logic        selected_trigger_input, // raw trigger level
	input  wire t2s_src_t    src,                    // clock and event sources
	output logic             clock_output_pin,       // clock out or pwm
	output logic             full_overflow_event,    // exported overflow pulse
	output logic             tx_baud_clk,            // transmit baud pulse
	output logic             rx_baud_clk,            // receive baud pulse
	output logic             timer_irq               // shared interrupt request
);

	t2s_state_t st_reg;
	t2s_state_t st_next;

	logic        take, trg, rise, fall, ext_evt, pin_fall, div_tick;
	logic        main_tick, low_tick, split, brg, clkout, duty;
	logic        ovf16, low_ovf, hi_ovf, set_tf, set_exf, set_low_byte_overflow_flag;
	logic [2:0]  mode;
	logic [15:0] cnt16;
	logic [7:0]  wd;

	// register read view
	function automatic logic [31:0] t2s_rd(input logic [7:0] a, input t2s_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			T2S_CTRL_OFS:  v = {s.tf, s.exf, s.bank ? s.low_byte_overflow_flag : s.rclk,
				s.bank ? s.low_overflow_irq_enable : s.tx_baud_source_sel, s.exen, s.run, s.ct, s.cprl};
			T2S_MODE_OFS:  v = {s.spl, s.bank ? s.inv : s.lbit, s.rise_en, s.x12,
				s.lrun, s.lrc, s.oe, s.ms0};
			T2S_MODE1_OFS: v = {s.lcs, s.ig, s.bank, s.cks, s.ms1, s.cap_src};
			T2S_CNTL_OFS:  v = s.cnt_l;
			T2S_CNTH_OFS:  v = s.cnt_h;
			T2S_CAPL_OFS:  v = s.cap_l;
			T2S_CAPH_OFS:  v = s.cap_h;
			default:       v = 8'h00;
		endcase
		return {24'h000000, v};
	endfunction

	// next state of the whole block
	always_comb
	begin
		st_next = st_reg;
		wd = hwdata[7:0];
		take = hsel & htrans[1] & hready;
		set_tf = 1'b0;
		set_exf = 1'b0;
		set_low_byte_overflow_flag = 1'b0;
		ovf16 = 1'b0;
		low_ovf = 1'b0;
		hi_ovf = 1'b0;
		main_tick = 1'b0;
		low_tick = 1'b0;
		cnt16 = {st_reg.cnt_h, st_reg.cnt_l};

		// pin synchronisers and edge detection
		st_next.trg_s1 = selected_trigger_input;
		st_next.trg_s2 = st_reg.trg_s1;
		st_next.pin_s1 = src.count_pin;
		st_next.pin_s2 = st_reg.pin_s1;
		trg = st_reg.trg_s2 ^ st_reg.inv;
		st_next.trg_q = trg;
		st_next.pin_q = st_reg.pin_s2;
		rise = trg & ~st_reg.trg_q;
		fall = ~trg & st_reg.trg_q;
		pin_fall = ~st_reg.pin_s2 & st_reg.pin_q;
		ext_evt = (fall & st_reg.exen) | (rise & st_reg.rise_en);

		// system clock divided by twelve
		div_tick = (st_reg.div == T2S_DIV12_LAST);
		st_next.div = div_tick ? 4'h0 : st_reg.div + 4'h1;

		// mode decode
		mode = {st_reg.ms1, st_reg.cprl, st_reg.ms0};
		split = st_reg.spl;
		duty = ~split & (mode == T2S_MD_DUTY);
		brg = ~split & (st_reg.rclk | st_reg.tx_baud_source_sel);
		clkout = ~st_reg.cprl & st_reg.oe;

		// low-byte clock in split mode
		case ({st_reg.lcs, st_reg.lbit})
			2'b00:   low_tick = div_tick;
			2'b01:   low_tick = 1'b1;
			2'b10:   low_tick = src.serial_ovf;
			default: low_tick = src.int0_evt;
		endcase

		// split low byte always auto-reloads; pwm holds it as compare value
		if (split && mode != T2S_MD_PWM && st_reg.lrun && low_tick)
		begin
			low_ovf = (st_reg.cnt_l == T2S_BYTE_MAX);
			st_next.cnt_l = low_ovf ? st_reg.cap_l : st_reg.cnt_l + 8'h01;
			set_low_byte_overflow_flag = low_ovf;
		end

		// main clock source, high byte in split mode
		case ({st_reg.cks, st_reg.x12, st_reg.ct})
			3'b000:  main_tick = div_tick;
			3'b001:  main_tick = pin_fall;
			3'b010:  main_tick = 1'b1;
			3'b011:  main_tick = split ? low_ovf : src.int0_evt;
			3'b100:  main_tick = src.serial_ovf;
			3'b101:  main_tick = src.t0_ovf;
			3'b110:  main_tick = src.acmp_evt;
			default: main_tick = src.kbi_evt;
		endcase

		if (split)
		begin
			// high byte under the main run bit
			if (st_reg.run && main_tick)
			begin
				hi_ovf = (st_reg.cnt_h == T2S_BYTE_MAX);
				if (hi_ovf && mode != T2S_MD_CAP && mode != T2S_MD_CAPZ)
					st_next.cnt_h = st_reg.cap_h;
				else
					st_next.cnt_h = st_reg.cnt_h + 8'h01;
			end
			if (hi_ovf)
			begin
				set_tf = 1'b1;
				if (mode == T2S_MD_PWM)
					st_next.cnt_l = st_reg.cap_l;
				else if (st_reg.lrc && (mode == T2S_MD_AR || mode == T2S_MD_ARX))
					st_next.lrun = 1'b0;
			end
			// trigger event on the high byte
			if (ext_evt)
			begin
				set_exf = 1'b1;
				case (mode)
					T2S_MD_ARX: st_next.cnt_h = st_reg.cap_h;
					T2S_MD_CAP: st_next.cap_h = st_reg.cnt_h;
					T2S_MD_CAPZ:
					begin
						st_next.cap_h = st_reg.cnt_h;
						st_next.cnt_h = 8'h00;
					end
					default: st_next.cap_h = st_reg.cap_h;
				endcase
				if (st_reg.lrc && (mode == T2S_MD_CAP || mode == T2S_MD_CAPZ))
					st_next.lrun = 1'b0;
			end
			// output: pwm waveform or low-byte clock
			if (mode == T2S_MD_PWM)
				st_next.ckout = st_reg.cnt_h < st_reg.cnt_l;
			else if (low_ovf && clkout)
				st_next.ckout = ~st_reg.ckout;
		end
		else if (duty)
		begin
			// three-edge duty and cycle measurement
			case (st_reg.dstate)
				T2S_D_IDLE:
					if (st_reg.run)
						st_next.dstate = T2S_D_WAIT;
				T2S_D_WAIT:
					if (!st_reg.run)
						st_next.dstate = T2S_D_IDLE;
					else if (rise)
					begin
						cnt16 = 16'h0000;
						st_next.dstate = T2S_D_FIRST;
					end
				T2S_D_FIRST, T2S_D_SECOND:
					if (!st_reg.run)
						st_next.dstate = T2S_D_IDLE;
					else
					begin
						if (main_tick)
						begin
							ovf16 = (cnt16 == T2S_WORD_MAX);
							set_tf = ovf16;
							cnt16 = cnt16 + 16'h0001;
						end
						if (st_reg.dstate == T2S_D_FIRST && fall)
						begin
							st_next.dstate = T2S_D_SECOND;
							if (st_reg.exen)
							begin
								{st_next.cap_h, st_next.cap_l} = {st_reg.cnt_h, st_reg.cnt_l};
								set_exf = 1'b1;
							end
						end
						else if (st_reg.dstate == T2S_D_SECOND && rise)
						begin
							cnt16 = {st_reg.cnt_h, st_reg.cnt_l};
							st_next.run = 1'b0;
							st_next.dstate = T2S_D_DONE;
						end
					end
				T2S_D_DONE:
					if (st_reg.run)
						st_next.dstate = T2S_D_WAIT;
				default: st_next.dstate = T2S_D_IDLE;
			endcase
			{st_next.cnt_h, st_next.cnt_l} = cnt16;
		end
		else
		begin
			// 16-bit auto-reload, capture, baud and clock-out
			if (st_reg.run && main_tick)
			begin
				ovf16 = (cnt16 == T2S_WORD_MAX);
				set_tf = ovf16;
				if (ovf16 && (brg || clkout || mode == T2S_MD_AR || mode == T2S_MD_ARX))
					cnt16 = {st_reg.cap_h, st_reg.cap_l};
				else
					cnt16 = cnt16 + 16'h0001;
			end
			if (ext_evt)
			begin
				set_exf = 1'b1;
				if (!brg)
				begin
					case (mode)
						T2S_MD_ARX: cnt16 = {st_reg.cap_h, st_reg.cap_l};
						T2S_MD_CAP: {st_next.cap_h, st_next.cap_l} = cnt16;
						T2S_MD_CAPZ:
						begin
							{st_next.cap_h, st_next.cap_l} = cnt16;
							cnt16 = 16'h0000;
						end
						default: cnt16 = cnt16;
					endcase
				end
			end
			{st_next.cnt_h, st_next.cnt_l} = cnt16;
			if (ovf16 && clkout)
				st_next.ckout = ~st_reg.ckout;
		end
		if (!duty)
			st_next.dstate = T2S_D_IDLE;

		// register write in the data phase, bank chosen by the stored select
		if (st_reg.wr_pend)
		begin
			case (st_reg.wr_addr)
				T2S_CTRL_OFS:
				begin
					st_next.tf = wd[T2S_C_TF];
					st_next.exf = wd[T2S_C_EXF];
					if (st_reg.bank)
					begin
						st_next.low_byte_overflow_flag = wd[T2S_C_B5];
						st_next.low_overflow_irq_enable = wd[T2S_C_B4];
					end
					else
					begin
						st_next.rclk = wd[T2S_C_B5];
						st_next.tx_baud_source_sel = wd[T2S_C_B4];
					end
					st_next.exen = wd[T2S_C_EXEN];
					st_next.run = wd[T2S_C_RUN];
					st_next.ct = wd[T2S_C_CT];
					st_next.cprl = wd[T2S_C_CPRL];
				end
				T2S_MODE_OFS:
				begin
					st_next.spl = wd[T2S_M_SPL];
					if (st_reg.bank)
						st_next.inv = wd[T2S_M_B6];
					else
						st_next.lbit = wd[T2S_M_B6];
					st_next.rise_en = wd[T2S_M_RISE];
					st_next.x12 = wd[T2S_M_X12];
					st_next.lrun = wd[T2S_M_LRUN];
					st_next.lrc = wd[T2S_M_LRC];
					st_next.oe = wd[T2S_M_OE];
					st_next.ms0 = wd[T2S_M_MS0];
				end
				T2S_MODE1_OFS:
				begin
					st_next.lcs = wd[T2S_M1_LCS];
					st_next.ig = wd[T2S_M1_IG];
					st_next.bank = wd[T2S_M1_BANK];
					st_next.cks = wd[T2S_M1_CKS];
					st_next.ms1 = wd[T2S_M1_MS1];
					st_next.cap_src = wd[2:0];
				end
				T2S_CNTL_OFS: st_next.cnt_l = wd;
				T2S_CNTH_OFS: st_next.cnt_h = wd;
				T2S_CAPL_OFS: st_next.cap_l = wd;
				T2S_CAPH_OFS: st_next.cap_h = wd;
				default:      st_next.cap_src = st_next.cap_src;
			endcase
		end

		// hardware sets win over a clearing write; no hardware clear
		if (set_tf)
			st_next.tf = 1'b1;
		if (set_exf)
			st_next.exf = 1'b1;
		if (set_low_byte_overflow_flag)
			st_next.low_byte_overflow_flag = 1'b1;

		// outputs
		if (!st_next.oe)
			st_next.ckout = 1'b0;
		st_next.ovf_evt = split ? low_ovf : ovf16;
		st_next.tx_baud = st_reg.tx_baud_source_sel ? st_next.ovf_evt : src.t1_ovf;
		st_next.rx_baud = st_reg.rclk ? st_next.ovf_evt : src.t1_ovf;
		st_next.irq = (st_next.tf & ~st_next.ig) | st_next.exf
			| (st_next.low_byte_overflow_flag & st_next.low_overflow_irq_enable);

		// bus address phase; read data reflects this cycle's write
		st_next.ready = 1'b1;
		st_next.wr_pend = take & hwrite;
		if (take)
			st_next.wr_addr = haddr[7:0];
		if (take && !hwrite)
			st_next.rdata = (haddr[31:8] == 24'h000000) ? t2s_rd(haddr[7:0], st_next)
				: T2S_RD_UNMAPPED;
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_reg <= '0;
			st_reg.ready <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign hrdata = st_reg.rdata;
	assign hreadyout = st_reg.ready;
	assign hresp = 1'b0;
	assign clock_output_pin = st_reg.ckout;
	assign full_overflow_event = st_reg.ovf_evt;
	assign tx_baud_clk = st_reg.tx_baud;
	assign rx_baud_clk = st_reg.rx_baud;
	assign timer_irq = st_reg.irq;

	// checks
	sequence s_duty_first;
		duty && st_reg.run && st_reg.dstate == T2S_D_WAIT && rise && !st_reg.wr_pend;
	endsequence
	sequence s_duty_third;
		duty && st_reg.run && st_reg.dstate == T2S_D_SECOND && rise && !st_reg.wr_pend;
	endsequence

	a_duty_first_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		s_duty_first |=> ({st_reg.cnt_h, st_reg.cnt_l} == 16'h0000
			&& st_reg.dstate == T2S_D_FIRST))
		else $error("duty count did not start from zero");
	a_duty_first_noflag: assert property (@(posedge hclk) disable iff (!hresetn)
		s_duty_first and !st_reg.exf |=> !st_reg.exf)
		else $error("first duty edge set the external flag");
	a_duty_third_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		s_duty_third |=> !st_reg.run ##1 $stable({st_reg.cnt_h, st_reg.cnt_l}) || $past(st_reg.wr_pend))
		else $error("third duty edge did not stop the counter");
	a_split_flags_kept: assert property (@(posedge hclk) disable iff (!hresetn)
		split && st_reg.low_byte_overflow_flag && !st_reg.wr_pend |=> st_reg.low_byte_overflow_flag)
		else $error("low overflow flag cleared by hardware");
	a_low_ovf_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		low_ovf |=> st_reg.low_byte_overflow_flag && st_reg.ovf_evt)
		else $error("low rollover did not set flag and event");
	a_export_source: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> st_reg.ovf_evt == ($past(split) ? $past(low_ovf) : $past(ovf16)))
		else $error("exported overflow from wrong source");
	a_clk_gated: assert property (@(posedge hclk) disable iff (!hresetn)
		st_reg.ckout |-> st_reg.oe)
		else $error("clock output driven while disabled");
	a_clkout_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
		!split && clkout && ovf16 |=> st_reg.ckout != $past(st_reg.ckout) || !st_reg.oe)
		else $error("clock output missed a toggle");
	a_pwm_reload: assert property (@(posedge hclk) disable iff (!hresetn)
		split && mode == T2S_MD_PWM && hi_ovf && !st_reg.wr_pend
		|=> st_reg.cnt_l == $past(st_reg.cap_l) && st_reg.tf)
		else $error("pwm overflow did not load compare value");
	a_brg_no_reload: assert property (@(posedge hclk) disable iff (!hresetn)
		brg && !duty && ext_evt && st_reg.run && main_tick && !st_reg.wr_pend
		|=> st_reg.exf && {st_reg.cnt_h, st_reg.cnt_l} == ($past(ovf16)
			? $past({st_reg.cap_h, st_reg.cap_l})
			: $past({st_reg.cnt_h, st_reg.cnt_l}) + 16'h0001))
		else $error("baud trigger disturbed the counter");

endmodule

// ==== t2s_testbench.sv ====
/*
 self-checking bench of the split timer: register access, clock output,
 baud selection, split clock output, split pwm and duty capture.
 assumes t2s_pkg and t2s_timer, a zero-wait slave and a 50 MHz hclk.
*/
`timescale 1ns/1ps
module testbench;
	import t2s_pkg::*;
	logic        hclk       = 1'b0;
	logic        hresetn    = 1'b0;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h0;
	logic        trg        = 1'b0;
	t2s_src_t    src        = 7'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        ckpin;
	logic        ovf;
	logic        txb;
	logic        rxb;
	logic        irq;
	logic [31:0] rd;
	logic [7:0]  rl;
	logic [15:0] cnt;
	int          num_errors = 0;
	int          n_checks   = 0;
	int          seed       = 41;
	int          no, nt, nr, np, t0, n1, n2;

	// 50 MHz system clock
	always #10 hclk = ~hclk;

	t2s_timer dut (
		.hclk                   (hclk),
		.hresetn                (hresetn),
		.hsel                   (hsel),
		.haddr                  (haddr),
		.htrans                 (htrans),
		.hwrite                 (hwrite),
		.hsize                  (3'h2),
		.hwdata                 (hwdata),
		.hready                 (hreadyout),
		.hrdata                 (hrdata),
		.hreadyout              (hreadyout),
		.hresp                  (hresp),
		.selected_trigger_input (trg),
		.src                    (src),
		.clock_output_pin       (ckpin),
		.full_overflow_event    (ovf),
		.tx_baud_clk            (txb),
		.rx_baud_clk            (rxb),
		.timer_irq              (irq)
	);

	// verdict and end of run
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// a wait that ran out counts as a mismatch and ends the run
	task automatic hang_out;
		num_errors++;
		close_out();
	endtask

	// one comparison of a value
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// next edge at which the slave is ready
	task automatic rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			k++;
			if (k > 50)
				hang_out();
			@(posedge hclk);
		end
	endtask

	// one single word transfer, read data left in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		rdy();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, {24'h0, e}, rd);
	endtask

	// a 16-bit pair, high byte first
	task automatic rd16(input logic [7:0] lo, input logic [7:0] hi);
		bus(1'b0, hi, 32'h0);
		cnt[15:8] = rd[7:0];
		bus(1'b0, lo, 32'h0);
		cnt[7:0] = rd[7:0];
	endtask

	// cycles until the clock pin changes
	task automatic tog(output int c);
		logic p;
		p = ckpin;
		c = 0;
		do
		begin
			@(posedge hclk);
			c++;
			if (c > 2000)
				hang_out();
		end
		while (ckpin === p);
	endtask

	// counts pulses and pin-high cycles, one timer 1 overflow pulse inside
	task automatic watch(input int n);
		no = 0;
		nt = 0;
		nr = 0;
		np = 0;
		for (int i = 0; i < n; i++)
		begin
			src.t1_ovf <= (i == 2);
			@(posedge hclk);
			no += ovf;
			nt += txb;
			nr += rxb;
			np += ckpin;
		end
	endtask

	// cycles between toggles for a counter of the given span
	function automatic int half(input int span, input int rel);
		return span - rel;
	endfunction

	// pwm high cycles over two periods of sixteen
	function automatic int pwm_hi(input int d);
		return 2 * (d - 240);
	endfunction

	// value within one count of the expected one
	function automatic logic [31:0] near(input int v, input int e);
		return {31'h0, (v >= e - 1) && (v <= e + 1)};
	endfunction

	// main sequence
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("ctrl_rst", T2S_CTRL_OFS, 8'h00);
		rchk("mode_rst", T2S_MODE_OFS, 8'h00);
		wr(8'h1c, 8'h5a);
		rchk("unmapped", 8'h1c, 8'h00);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hready", 32'h1, {31'h0, hreadyout});
		// 16-bit clock output, reload 0xfffe from the system clock
		wr(T2S_CAPL_OFS, 8'hfe);
		wr(T2S_CAPH_OFS, 8'hff);
		wr(T2S_CNTL_OFS, 8'hfe);
		wr(T2S_CNTH_OFS, 8'hff);
		wr(T2S_MODE_OFS, 8'h13);
		wr(T2S_CTRL_OFS, 8'h04);
		tog(t0);
		tog(t0);
		chk("ck_half", half(32'h10000, 16'hfffe), t0);
		rchk("tf_set", T2S_CTRL_OFS, 8'h84);
		chk("irq_tf", 32'h1, {31'h0, irq});
		// transmit baud from this timer, receive from timer 1, falling trigger
		wr(T2S_CTRL_OFS, 8'h1c);
		trg <= 1'b1;
		watch(40);
		chk("tx_baud", 32'h14, nt);
		chk("rx_baud", 32'h1, nr);
		chk("ovf_16", 32'h14, no);
		trg <= 1'b0;
		watch(8);
		rchk("exf_baud", T2S_CTRL_OFS, 8'hdc);
		// split low-byte clock output from the system clock
		wr(T2S_CTRL_OFS, 8'h00);
		// second clear: an overflow landing with the first one sets the flag again
		wr(T2S_CTRL_OFS, 8'h00);
		rl = 8'hf0 | 8'($random(seed));
		wr(T2S_MODE_OFS, 8'hc0);
		wr(T2S_CAPL_OFS, rl);
		wr(T2S_CNTL_OFS, rl);
		wr(T2S_MODE_OFS, 8'hca);
		tog(t0);
		tog(t0);
		chk("split_half", half(32'h100, rl), t0);
		watch(4 * half(32'h100, rl));
		chk("low_ovf_evt", 32'h4, no);
		wr(T2S_MODE1_OFS, 8'h20);
		rchk("low_flag", T2S_CTRL_OFS, 8'h20);
		chk("irq_masked", 32'h0, {31'h0, irq});
		wr(T2S_CTRL_OFS, 8'h30);
		repeat (3) @(posedge hclk);
		chk("irq_low", 32'h1, {31'h0, irq});
		// split pwm, period sixteen, gated then enabled
		wr(T2S_MODE_OFS, 8'h00);
		wr(T2S_MODE1_OFS, 8'h08);
		wr(T2S_CAPH_OFS, 8'hf0);
		wr(T2S_CNTH_OFS, 8'hf0);
		wr(T2S_CAPL_OFS, rl);
		wr(T2S_CNTL_OFS, rl);
		wr(T2S_MODE_OFS, 8'h90);
		wr(T2S_CTRL_OFS, 8'h04);
		watch(32);
		chk("pwm_gated", 32'h0, np);
		wr(T2S_MODE_OFS, 8'h92);
		repeat (2) @(posedge hclk);
		watch(32);
		chk("pwm_high", pwm_hi(rl), np);
		// duty capture, falling enable clear then set
		n1 = 20 + ({$random(seed)} % 30);
		n2 = 20 + ({$random(seed)} % 30);
		for (int e = 0; e < 2; e++)
		begin
			wr(T2S_CTRL_OFS, 8'h00);
			wr(T2S_CNTL_OFS, 8'h00);
			wr(T2S_CNTH_OFS, 8'h00);
			wr(T2S_CAPL_OFS, 8'h00);
			wr(T2S_CAPH_OFS, 8'h00);
			wr(T2S_MODE_OFS, 8'h30);
			wr(T2S_CTRL_OFS, (e != 0) ? 8'h0d : 8'h05);
			repeat (10) @(posedge hclk);
			rchk("held", T2S_CNTL_OFS, 8'h00);
			trg <= 1'b1;
			repeat (n1) @(posedge hclk);
			trg <= 1'b0;
			repeat (n2) @(posedge hclk);
			trg <= 1'b1;
			repeat (10) @(posedge hclk);
			rchk("duty_ctrl", T2S_CTRL_OFS, (e != 0) ? 8'h49 : 8'h01);
			rd16(T2S_CNTL_OFS, T2S_CNTH_OFS);
			chk("cycle_len", 32'h1, near(cnt, n1 + n2));
			rd16(T2S_CAPL_OFS, T2S_CAPH_OFS);
			chk("pulse_w", 32'h1, near(cnt, (e != 0) ? n1 : 0));
			trg <= 1'b0;
		end
		// 16-bit capture with auto-zero on a rising trigger
		wr(T2S_CTRL_OFS, 8'h00);
		wr(T2S_MODE1_OFS, 8'h00);
		wr(T2S_CNTL_OFS, 8'h00);
		wr(T2S_CNTH_OFS, 8'h00);
		wr(T2S_MODE_OFS, 8'h31);
		wr(T2S_CTRL_OFS, 8'h05);
		repeat (n1) @(posedge hclk);
		trg <= 1'b1;
		repeat (10) @(posedge hclk);
		rchk("capz_ctrl", T2S_CTRL_OFS, 8'h45);
		wr(T2S_CTRL_OFS, 8'h01);
		rd16(T2S_CNTL_OFS, T2S_CNTH_OFS);
		chk("capz_zero", 32'h1, near(cnt, 11));
		rd16(T2S_CAPL_OFS, T2S_CAPH_OFS);
		chk("capz_cap", 32'h1, near(cnt, n1 + 3));
		close_out();
	end
endmodule
